// ===== lws_pkg.sv
`default_nettype none
// -----------------------------------------------------------------
// Shared constants of the late-write cycle control
// -----------------------------------------------------------------
package lws_pkg;
  localparam int LANES = 4; // Byte lanes per word
  localparam int LANE_W = 9; // Bits per lane, parity included
  localparam int DATA_W = LANES * LANE_W; // Full word width
  localparam int ADDR_W = 17; // Word address width
  localparam int WORDS = 1 << ADDR_W; // Array depth
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hF; // All lane enables high
  localparam logic [LANES-1:0] MASK_NONE = 4'h0; // No lane selected
  localparam logic [DATA_W-1:0] WORD_ZERO = 36'h0_0000_0000; // Reset data
  localparam logic [DATA_W-1:0] OE_ALL_OFF_N = 36'hF_FFFF_FFFF; // All drivers off
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0_0000; // Reset address
  // Decoded command of one clock edge
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_READ,
    CMD_WRITE,
    CMD_ABORT
  } lws_cmd_t;
endpackage : lws_pkg
`default_nettype wire

// ===== lws_core.sv
// Function
// - Read drives all 36 bits next cycle
// - Lane 0 alone writes bits 0 to 8
// - Lane 1 alone writes bits 9 to 17
// - Lane 2 alone writes bits 18 to 26
// - Lane 3 alone writes bits 27 to 35
// - All lanes low writes whole word
// - No lane enabled aborts write, stays off
// - Chip deselected: no access, outputs off next
// - Write cycle off; data taken one cycle late
// - Write strobe offs now; select changes later
// - Async output enable high forces off
// - Commands sampled only at rising edge
`timescale 1ns/1ps
`default_nettype none
module lws_core
  import lws_pkg::*;
(
  input wire logic mclk_i, // 125 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic sleep_request_i, // Sleep, active high
  input wire logic chip_sel_n_i, // Chip select, active low
  input wire logic write_strobe_n_i, // Write strobe, active low
  input wire logic lane0_write_en_n_i, // Lane 0 write enable, active low
  input wire logic lane1_write_en_n_i, // Lane 1 write enable, active low
  input wire logic lane2_write_en_n_i, // Lane 2 write enable, active low
  input wire logic lane3_write_en_n_i, // Lane 3 write enable, active low
  input wire logic out_en_n_i, // Async output enable, active low
  input wire logic [ADDR_W-1:0] address_in_i, // Word address
  input wire logic [DATA_W-1:0] dq_i, // Data pins, input side
  output logic [DATA_W-1:0] dq_o, // Data pins, output side
  output logic [DATA_W-1:0] dq_oe_n_o // Data pin enables, low drives
);
  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic rst_meta; // First stage, read only by second
  logic rst_n; // Synchronised reset
  // Two flops, so that the release never lands near a clock edge inside the block
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // -----------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------
  logic [LANES-1:0] lane_en_n; // Gathered lane enables
  lws_cmd_t cmd; // Command at this edge
  assign lane_en_n = {lane3_write_en_n_i, lane2_write_en_n_i, lane1_write_en_n_i, lane0_write_en_n_i};

  // Decode the command of this edge; only edge-sampled use follows
  always_comb begin
    cmd = CMD_IDLE; // Sleep or deselect: no access
    if (!sleep_request_i && !chip_sel_n_i) begin
      if (write_strobe_n_i) begin
        cmd = CMD_READ; // Lane enables ignored on reads
      end else if (lane_en_n == LANES_OFF_N) begin
        cmd = CMD_ABORT;
      end else begin
        cmd = CMD_WRITE;
      end
    end
  end

  // -----------------------------------------------------------------
  // Array and lane merge
  // -----------------------------------------------------------------
  logic [DATA_W-1:0] mem [WORDS]; // Storage array, no reset
  logic wr_pend; // Write data due this cycle
  logic [ADDR_W-1:0] wr_addr; // Address of pending write
  logic [LANES-1:0] wr_mask; // Lanes of pending write
  logic [DATA_W-1:0] wr_word; // Merged word to store
  logic [DATA_W-1:0] rd_word; // Read word with late-write bypass
  logic [DATA_W-1:0] old_word; // Stored word at pending address
  logic [DATA_W-1:0] cur_word; // Stored word at read address
  logic hit; // Read hits the pending write

  assign old_word = mem[wr_addr];
  assign cur_word = mem[address_in_i];
  assign hit = wr_pend && (wr_addr == address_in_i);

  // Per lane: late data replaces only enabled lanes
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign wr_word[l*LANE_W +: LANE_W] =
      wr_mask[l] ? dq_i[l*LANE_W +: LANE_W] : old_word[l*LANE_W +: LANE_W];
    // Bypass so a read right after a write sees new data
    assign rd_word[l*LANE_W +: LANE_W] = (hit && wr_mask[l]) ?
      dq_i[l*LANE_W +: LANE_W] : cur_word[l*LANE_W +: LANE_W];
  end

  // Commit the late data one edge after the command
  always_ff @(posedge mclk_i) begin
    if (ce_i && rst_n && !sleep_request_i && wr_pend) begin
      mem[wr_addr] <= wr_word;
    end
  end

  // -----------------------------------------------------------------
  // Cycle state
  // -----------------------------------------------------------------
  logic drive_en; // Registered output drive
  logic next_drive_en;
  logic next_wr_pend;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [LANES-1:0] next_wr_mask;
  logic [DATA_W-1:0] next_dq;

  // Next values; sleep holds everything as it was
  always_comb begin
    next_drive_en = drive_en;
    next_wr_pend = wr_pend;
    next_wr_addr = wr_addr;
    next_wr_mask = wr_mask;
    next_dq = dq_o;
    if (!sleep_request_i) begin
      next_drive_en = (cmd == CMD_READ);
      next_wr_pend = 1'b0;
      unique case (cmd)
        CMD_READ: begin
          next_dq = rd_word;
        end
        CMD_WRITE: begin
          next_wr_pend = 1'b1;
          next_wr_addr = address_in_i;
          next_wr_mask = ~lane_en_n;
        end
        CMD_ABORT: begin
          next_wr_mask = MASK_NONE;
        end
        CMD_IDLE: begin
          next_wr_mask = wr_mask; // Deselect keeps last mask
        end
      endcase
    end
  end

  // Register only; enable freezes all but the internal reset clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_en <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= ADDR_ZERO;
      wr_mask <= MASK_NONE;
      dq_o <= WORD_ZERO;
    end else if (!rst_n) begin
      drive_en <= 1'b0;
      wr_pend <= 1'b0;
    end else if (ce_i) begin
      drive_en <= next_drive_en;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wr_mask <= next_wr_mask;
      dq_o <= next_dq;
    end
  end

  // -----------------------------------------------------------------
  // Output drive
  // -----------------------------------------------------------------
  // Gated without a clock: output enable, sleep and a low strobe act at once
  // A low strobe must free the pins in its own cycle, before any edge
  logic drive_now; // Drive allowed at this instant
  assign drive_now = drive_en && write_strobe_n_i && !out_en_n_i && !sleep_request_i;
  assign dq_oe_n_o = drive_now ? ~OE_ALL_OFF_N : OE_ALL_OFF_N;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  // Taken only at an edge where the internal reset was already released
  sequence s_cmd(lws_cmd_t c);
    ce_i && rst_n && cmd == c;
  endsequence
  sequence s_lane_write(logic [LANES-1:0] en_n);
    s_cmd(CMD_WRITE) ##0 lane_en_n == en_n;
  endsequence

  property p_read;
    s_cmd(CMD_READ) |=> drive_en && dq_o == $past(rd_word);
  endproperty
  a_read: assert property (p_read) else $error("read data not driven");

  property p_lane(logic [LANES-1:0] en_n);
    s_lane_write(en_n) |=> wr_pend && wr_mask == ~en_n;
  endproperty
  a_lane0: assert property (p_lane(4'hE)) else $error("lane 0 mask wrong");
  a_lane1: assert property (p_lane(4'hD)) else $error("lane 1 mask wrong");
  a_lane2: assert property (p_lane(4'hB)) else $error("lane 2 mask wrong");
  a_lane3: assert property (p_lane(4'h7)) else $error("lane 3 mask wrong");
  a_lane_all: assert property (p_lane(4'h0)) else $error("full word mask wrong");

  property p_commit;
    ce_i && wr_pend && !sleep_request_i |=> mem[$past(wr_addr)] == $past(wr_word);
  endproperty
  a_commit: assert property (p_commit) else $error("late data not stored");

  property p_abort;
    s_cmd(CMD_ABORT) |=> !wr_pend && dq_oe_n_o == OE_ALL_OFF_N;
  endproperty
  a_abort: assert property (p_abort) else $error("abort wrote or drove");

  property p_deselect;
    ce_i && chip_sel_n_i && !sleep_request_i |=> !drive_en && !wr_pend;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect accessed");

  property p_write_off;
    s_cmd(CMD_WRITE) |=> dq_oe_n_o == OE_ALL_OFF_N;
  endproperty
  a_write_off: assert property (p_write_off) else $error("driving in write");

  // Pins off while asleep; the edge taken asleep changes nothing
  sequence s_frozen;
    $stable(dq_o) && $stable(wr_addr);
  endsequence
  property p_sleep;
    ce_i && sleep_request_i |-> dq_oe_n_o == OE_ALL_OFF_N ##1 s_frozen;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep changed state");

  property p_strobe_off;
    !write_strobe_n_i |-> dq_oe_n_o == OE_ALL_OFF_N;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("driving with strobe low");

  property p_oe;
    out_en_n_i |-> dq_oe_n_o == OE_ALL_OFF_N;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable ignored");
endmodule : lws_core
`default_nettype wire

// ===== lws_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Controller data side for late writes
// ----------------------------------------
module lws_ctrl_model
  import lws_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic wr_cmd_i, // Write command shown this cycle
  input wire logic [DATA_W-1:0] wdata_i, // Data for the late cycle
  output logic [DATA_W-1:0] dq_o // Data pins toward the RAM
);
  logic pend = 1'b0; // Write taken at last edge
  initial dq_o = WORD_ZERO;
  always @(posedge mclk_i) pend <= wr_cmd_i;
  // Data one cycle late; else churn so stale data never matches
  always @(negedge mclk_i) dq_o <= pend ? wdata_i : ~dq_o;
endmodule : lws_ctrl_model
`default_nettype wire

// ===== late_write_sram_cycle_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module late_write_sram_cycle_control_tb;
  import lws_pkg::*;
  logic mclk_i = 1'b0, nrst_i = 1'b0, sleep_request_i = 1'b0, out_en_n_i = 1'b0;
  logic chip_sel_n_i = 1'b1, write_strobe_n_i = 1'b1; // Commands
  logic [LANES-1:0] ln_n = LANES_OFF_N; // Lane enables
  logic [ADDR_W-1:0] addr = 17'h1_0101; // Word under test
  logic [DATA_W-1:0] wdata = WORD_ZERO, exp_w = WORD_ZERO, mask, dq_i, dq_o, dq_oe_n_o;
  int n_errors = 0, checks_done = 0;
  // Rows: lane enables beside the late data
  logic [LANES-1:0] ln_tab [7] = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h5};
  logic [DATA_W-1:0] d_tab [7] = '{36'h1_2345_6789, 36'hA_AAAA_AAAA, 36'h5_5555_5555,
    36'hC_3C3C_3C3C, 36'h9_8765_4321, 36'hF_FFFF_FFFF, 36'h0_F0F0_F0F0};
  always #4 mclk_i = ~mclk_i;
  lws_core dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .sleep_request_i(sleep_request_i),
    .chip_sel_n_i(chip_sel_n_i), .write_strobe_n_i(write_strobe_n_i), .lane0_write_en_n_i(ln_n[0]),
    .lane1_write_en_n_i(ln_n[1]), .lane2_write_en_n_i(ln_n[2]), .lane3_write_en_n_i(ln_n[3]),
    .out_en_n_i(out_en_n_i), .address_in_i(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
  lws_ctrl_model ctrl (.mclk_i(mclk_i), .wr_cmd_i(!chip_sel_n_i && !write_strobe_n_i),
    .wdata_i(wdata), .dq_o(dq_i));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic cmd(input logic cs, input logic ws, input logic [LANES-1:0] ln);
    @(negedge mclk_i);
    chip_sel_n_i = cs;
    write_strobe_n_i = ws;
    ln_n = ln;
  endtask : cmd
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("dq_o", WORD_ZERO, dq_o);
    chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    // Dead cycle, write, late data, read back, deselect
    for (int i = 0; i < 7; i++) begin
      cmd(1'b1, 1'b1, LANES_OFF_N);
      cmd(1'b0, 1'b0, ln_tab[i]);
      wdata = d_tab[i];
      for (int l = 0; l < LANES; l++) mask[l*LANE_W+:LANE_W] = {LANE_W{~ln_tab[i][l]}};
      exp_w = (exp_w & ~mask) | (wdata & mask);
      cmd(1'b1, 1'b1, LANES_OFF_N);
      chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
      cmd(1'b0, 1'b1, MASK_NONE);
      cmd(1'b1, 1'b1, LANES_OFF_N);
      chk("dq_o", exp_w, dq_o);
      chk("dq_oe_n_o", WORD_ZERO, dq_oe_n_o);
      cmd(1'b1, 1'b1, LANES_OFF_N);
      chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    end
    // Read in the late data cycle sees the new word
    cmd(1'b0, 1'b0, MASK_NONE);
    wdata = 36'h7_1E2D_3C4B;
    exp_w = wdata;
    cmd(1'b0, 1'b1, LANES_OFF_N);
    cmd(1'b1, 1'b0, MASK_NONE); // Deselect with strobe low
    wdata = 36'h0_0000_FFFF;
    chk("dq_o", exp_w, dq_o);
    #1 chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    cmd(1'b0, 1'b1, LANES_OFF_N);
    cmd(1'b1, 1'b1, LANES_OFF_N);
    chk("dq_o", exp_w, dq_o);
    // Sleep and output enable cut drive at once
    sleep_request_i = 1'b1;
    #1 chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    sleep_request_i = 1'b0;
    out_en_n_i = 1'b1;
    #1 chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    out_en_n_i = 1'b0;
    #1 chk("dq_oe_n_o", WORD_ZERO, dq_oe_n_o);
    // Sleep across an edge: the read shown then is ignored
    cmd(1'b0, 1'b1, LANES_OFF_N);
    sleep_request_i = 1'b1;
    cmd(1'b1, 1'b1, LANES_OFF_N);
    sleep_request_i = 1'b0;
    #1 chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    // Mid-run reset: outputs clear, early read refused, array kept
    cmd(1'b0, 1'b1, LANES_OFF_N);
    cmd(1'b1, 1'b1, LANES_OFF_N);
    chk("dq_oe_n_o", WORD_ZERO, dq_oe_n_o);
    nrst_i = 1'b0;
    #1 chk("dq_o", WORD_ZERO, dq_o);
    chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    repeat (2) @(negedge mclk_i);
    nrst_i = 1'b1;
    chip_sel_n_i = 1'b0; // Read held from the release on, too early for two edges
    repeat (2) begin
      @(negedge mclk_i);
      chk("dq_o", WORD_ZERO, dq_o);
      chk("dq_oe_n_o", OE_ALL_OFF_N, dq_oe_n_o);
    end
    @(negedge mclk_i);
    chk("dq_o", exp_w, dq_o);
    chk("dq_oe_n_o", WORD_ZERO, dq_oe_n_o);
    close_out();
  end
endmodule : late_write_sram_cycle_control_tb
`default_nettype wire
